// ---- sst_far_side.sv ----
// Far side model: a second source on the shared clock line and four
// converters whose outputs clear the UV limit 50 cycles after enable.
// Assumes a 10 MHz clk and an open-drain shared clock pin on the device.
`timescale 1ns/10ps
`default_nettype none
module sst_far_side (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic share_clk_out,
  input wire logic share_clk_oe,
  input wire logic [3:0] converter_enable_out,
  input wire logic [3:0] good_mask,
  output logic share_clk_in,
  output logic [3:0] uv_ok
);
  logic [6:0] phase;
  logic [7:0] rise_cnt [4];
  // The line has a pull-up, so it is high unless some party pulls it low.
  assign share_clk_in = !(phase < 7'h1E || (share_clk_oe && !share_clk_out));
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      phase <= 7'h00;
    else
      phase <= (phase == 7'h63) ? 7'h00 : phase + 7'h01;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      rise_cnt <= '{default: 8'h00};
    else
      for (int i = 0; i < 4; i++)
        if (!converter_enable_out[i])
          rise_cnt[i] <= 8'h00;
        else if (rise_cnt[i] != 8'hFF)
          rise_cnt[i] <= rise_cnt[i] + 8'h01;
  always_comb
    for (int i = 0; i < 4; i++)
      uv_ok[i] = good_mask[i] && rise_cnt[i] >= 8'h32;
endmodule // sst_far_side
`default_nettype wire

// ---- sst_pkg.sv ----
// Package for the supply sequencing timers: command codes, reset
// words, tick figures, carrier types and the timing word decoder.
// Assumes a 10 MHz system clock.
`default_nettype none
package sst_pkg;
  // ----------------------------------------
  // Command codes and reset words
  // ----------------------------------------
  localparam logic [7:0] CMD_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_RISE = 8'h61;
  localparam logic [7:0] CMD_MAX_ON = 8'h62;
  localparam logic [7:0] CMD_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_RESTART = 8'hDC;
  localparam logic [15:0] RST_ON_DELAY = 16'hBA00;
  localparam logic [15:0] RST_RISE = 16'hD280;
  localparam logic [15:0] RST_MAX_ON = 16'hD3C0;
  localparam logic [15:0] RST_OFF_DELAY = 16'hBA00;
  localparam logic [15:0] RST_RESTART = 16'hFB20;
  // ----------------------------------------
  // Time base
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 10_000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RS_STEP_NS = 200_000;
  localparam int RS_DIV = RS_STEP_NS / TICK_NS;
  localparam int MS_NS = 1_000_000;
  localparam logic [6:0] TICKS_PER_MS = 7'(MS_NS / TICK_NS);
  localparam logic [6:0] RS_PER_MS = 7'(MS_NS / RS_STEP_NS);
  localparam int MAX_TIME_US = 655_000;
  localparam logic [15:0] MAX_COUNT = 16'(MAX_TIME_US / 10);
  localparam logic [15:0] MIN_OFF_TICKS = 16'h0001;
  localparam int SYNC_LAT = 3;
  localparam int SHARE_LOSS_CYC = 2 * TICK_CYC;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic [1:0] page;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } sst_req_type;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_ON_DLY = 3'b001,
    ST_RISE = 3'b010,
    ST_ON = 3'b011,
    ST_OFF_DLY = 3'b100
  } sst_state_type;
  // Exponent/mantissa word to whole steps, rounded to nearest, clamped.
  function automatic logic [15:0] sst_l11_steps(input logic [15:0] w,
                                                input logic [6:0] scale);
    logic signed [4:0] e;
    logic signed [47:0] p;
    logic [4:0] sh;
    e = w[15:11];
    p = 48'(signed'(w[10:0]));
    p = p * signed'({41'h0, scale});
    sh = 5'(-e);
    if (e < 0)
      p = (p + (48'sd1 <<< (sh - 5'd1))) >>> sh;
    else
      p = p <<< e[3:0];
    if (p < 0)
      return 16'h0000;
    if (p > 48'(MAX_COUNT))
      return MAX_COUNT;
    return p[15:0];
  endfunction
endpackage
`default_nettype wire

// ---- sst_top.sv ----
// Per-channel power-up/down sequencing timers with a global restart timer.
// Assumes all inputs synchronous to clk; the shared clock pin is
// open-drain and its level is resolved outside.
`timescale 1ns/10ps
`default_nettype none
module sst_top #(
  parameter int N_CH = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire sst_pkg::sst_req_type reg_req,
  output logic [15:0] reg_rd_data,
  input wire logic ctrl_pin,
  input wire logic [N_CH-1:0] op_on,
  input wire logic [N_CH-1:0] dac_mode_zero,
  input wire logic [N_CH-1:0] uv_ok,
  input wire logic share_clk_in,
  output logic share_clk_out,
  output logic share_clk_oe,
  output logic [N_CH-1:0] converter_enable_out,
  output logic [N_CH-1:0] servo_engage,
  output logic [N_CH-1:0] uv_unmask,
  output logic [N_CH-1:0] ton_max_fault,
  output logic restart_hold
);
  import sst_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] tword [N_CH][4];
  logic [15:0] restart_word;

  function automatic logic [1:0] slot_of(input logic [7:0] c);
    unique case (c)
      CMD_RISE: return 2'h1;
      CMD_MAX_ON: return 2'h2;
      CMD_OFF_DELAY: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic is_paged(input logic [7:0] c);
    return (c == CMD_ON_DELAY) || (c == CMD_RISE) ||
           (c == CMD_MAX_ON) || (c == CMD_OFF_DELAY);
  endfunction

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < N_CH; i++)
      begin
        tword[i][0] <= RST_ON_DELAY;
        tword[i][1] <= RST_RISE;
        tword[i][2] <= RST_MAX_ON;
        tword[i][3] <= RST_OFF_DELAY;
      end
      restart_word <= RST_RESTART;
    end
    else if (reg_req.wr)
    begin
      if (is_paged(reg_req.cmd) && (32'(reg_req.page) < N_CH))
        tword[reg_req.page][slot_of(reg_req.cmd)] <= reg_req.wdata;
      else if (reg_req.cmd == CMD_RESTART)
        restart_word <= reg_req.wdata;
    end
  end

  // The raw word is returned; only the decoded copy is clamped.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rd_data <= 16'h0000;
    else if (is_paged(reg_req.cmd) && (32'(reg_req.page) < N_CH))
      reg_rd_data <= tword[reg_req.page][slot_of(reg_req.cmd)];
    else if (reg_req.cmd == CMD_RESTART)
      reg_rd_data <= restart_word;
    else
      reg_rd_data <= 16'h0000;
  end

  // ----------------------------------------
  // Shared clock
  // ----------------------------------------
  logic [7:0] osc_cnt;
  logic sh_s1;
  logic sh_s2;
  logic sh_s3;
  logic tick;
  logic [8:0] loss_cnt;
  logic share_ok;
  logic osc_tick;

  // Our oscillator pulls the line low for half a period; any earlier
  // falling edge from a faster part restarts our phase to follow it.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_cnt <= 8'h00;
      share_clk_oe <= 1'b0;
      share_clk_out <= 1'b0;
    end
    else
    begin
      if (tick)
        osc_cnt <= 8'(SYNC_LAT);
      else if (osc_cnt == 8'(TICK_CYC - 1))
        osc_cnt <= 8'h00;
      else
        osc_cnt <= osc_cnt + 8'h01;
      share_clk_oe <= (osc_cnt < 8'(TICK_CYC / 2));
      share_clk_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_s1 <= 1'b1;
      sh_s2 <= 1'b1;
      sh_s3 <= 1'b1;
      loss_cnt <= 9'h000;
    end
    else
    begin
      sh_s1 <= share_clk_in;
      sh_s2 <= sh_s1;
      sh_s3 <= sh_s2;
      if (tick)
        loss_cnt <= 9'h000;
      else if (loss_cnt != 9'(SHARE_LOSS_CYC))
        loss_cnt <= loss_cnt + 9'h001;
    end
  end

  assign tick = sh_s3 && !sh_s2;
  assign share_ok = (loss_cnt != 9'(SHARE_LOSS_CYC));
  assign osc_tick = (osc_cnt == 8'(TICK_CYC - 1));

  // ----------------------------------------
  // Restart timer
  // ----------------------------------------
  logic ctrl_q;
  logic [4:0] pre;
  logic rs_tick;
  logic [15:0] off_ticks;
  logic [15:0] off_units;
  logic [15:0] hold_units;
  logic [15:0] rs_val;

  assign rs_val = sst_l11_steps(restart_word, RS_PER_MS);
  assign rs_tick = tick && (pre == 5'(RS_DIV - 1));

  // The step prescaler runs free, so off and hold times carry up to
  // one 200 us step of uncertainty.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Idle level is on, so a pin already high at reset is not an edge.
      ctrl_q <= 1'b1;
      pre <= 5'h00;
      off_ticks <= 16'h0000;
      off_units <= 16'h0000;
      hold_units <= 16'h0000;
      restart_hold <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_pin;
      if (tick)
        pre <= (pre == 5'(RS_DIV - 1)) ? 5'h00 : pre + 5'h01;
      if (ctrl_pin && !ctrl_q)
      begin
        if ((rs_val != 16'h0000) && (off_ticks >= MIN_OFF_TICKS) &&
            (off_units <= rs_val))
          restart_hold <= 1'b1;
        hold_units <= 16'h0000;
      end
      else if (restart_hold)
      begin
        if (hold_units >= rs_val)
          restart_hold <= 1'b0;
        else if (rs_tick)
          hold_units <= hold_units + 16'h0001;
      end
      if (ctrl_pin)
      begin
        off_ticks <= 16'h0000;
        off_units <= 16'h0000;
      end
      else
      begin
        if (tick && (off_ticks != MAX_COUNT))
          off_ticks <= off_ticks + 16'h0001;
        if (rs_tick && (off_units != MAX_COUNT))
          off_units <= off_units + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar i = 0; i < N_CH; i++)
  begin : g_ch
    sst_state_type state;
    logic [15:0] cnt;
    logic [15:0] tmax_cnt;
    logic tmax_act;
    logic run;
    logic off_step;
    logic [15:0] t_on;
    logic [15:0] t_rise;
    logic [15:0] t_max;
    logic [15:0] t_off;

    assign t_on = sst_l11_steps(tword[i][0], TICKS_PER_MS);
    assign t_rise = sst_l11_steps(tword[i][1], TICKS_PER_MS);
    assign t_max = sst_l11_steps(tword[i][2], TICKS_PER_MS);
    assign t_off = sst_l11_steps(tword[i][3], TICKS_PER_MS);
    assign run = ctrl_pin && op_on[i] && !restart_hold;
    assign off_step = share_ok ? tick : osc_tick;

    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        state <= ST_OFF;
        cnt <= 16'h0000;
        converter_enable_out[i] <= 1'b0;
        servo_engage[i] <= 1'b0;
      end
      else if (restart_hold)
      begin
        state <= ST_OFF;
        converter_enable_out[i] <= 1'b0;
        servo_engage[i] <= 1'b0;
      end
      else
      begin
        unique case (state)
          ST_OFF:
            if (run)
            begin
              state <= ST_ON_DLY;
              cnt <= 16'h0000;
            end
          ST_ON_DLY:
            if (!run)
              state <= ST_OFF;
            else if (cnt >= t_on)
            begin
              state <= ST_RISE;
              converter_enable_out[i] <= 1'b1;
              cnt <= 16'h0000;
            end
            else if (tick)
              cnt <= cnt + 16'h0001;
          ST_RISE:
            if (!run)
            begin
              state <= ST_OFF_DLY;
              cnt <= 16'h0000;
            end
            else if (cnt >= t_rise)
            begin
              state <= ST_ON;
              servo_engage[i] <= dac_mode_zero[i];
            end
            else if (tick)
              cnt <= cnt + 16'h0001;
          ST_ON:
            if (!run)
            begin
              state <= ST_OFF_DLY;
              cnt <= 16'h0000;
            end
          ST_OFF_DLY:
            if (cnt >= t_off)
            begin
              state <= ST_OFF;
              converter_enable_out[i] <= 1'b0;
              servo_engage[i] <= 1'b0;
            end
            else if (off_step)
              cnt <= cnt + 16'h0001;
          default:
            state <= ST_OFF;
        endcase
      end
    end

    // The timeout runs from enable until the output clears UV.
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        tmax_act <= 1'b0;
        tmax_cnt <= 16'h0000;
        uv_unmask[i] <= 1'b0;
        ton_max_fault[i] <= 1'b0;
      end
      else
      begin
        ton_max_fault[i] <= 1'b0;
        if (!converter_enable_out[i])
        begin
          tmax_act <= 1'b0;
          uv_unmask[i] <= 1'b0;
          tmax_cnt <= 16'h0000;
        end
        // A spent count blocks re-arming, so one attempt gives one fault pulse.
        else if (!tmax_act && !uv_unmask[i] && (tmax_cnt == 16'h0000))
          tmax_act <= 1'b1;
        else if (tmax_act)
        begin
          if (uv_ok[i])
          begin
            tmax_act <= 1'b0;
            uv_unmask[i] <= 1'b1;
          end
          else if ((t_max != 16'h0000) && (tmax_cnt >= t_max))
          begin
            tmax_act <= 1'b0;
            ton_max_fault[i] <= 1'b1;
          end
          else if (tick)
            tmax_cnt <= tmax_cnt + 16'h0001;
        end
      end
    end

    AST_EN_AFTER_ON_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(converter_enable_out[i]) |-> $past(cnt) >= $past(t_on))
      else $error("enable raised before on-delay");
    AST_SERVO_AFTER_RISE: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(servo_engage[i]) |->
        $past(dac_mode_zero[i]) && ($past(cnt) >= $past(t_rise)) && converter_enable_out[i])
      else $error("servo engaged early or in wrong mode");
    AST_TMAX_FAULT: assert property (@(posedge clk) disable iff (!arst_n)
      ton_max_fault[i] |-> !uv_unmask[i] && ($past(tmax_cnt) >= $past(t_max)))
      else $error("turn-on fault before limit");
    AST_UV_UNMASK: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(uv_unmask[i]) |-> $past(uv_ok[i]) && converter_enable_out[i])
      else $error("unmask without output above limit");
    AST_ZERO_NO_TMAX: assert property (@(posedge clk) disable iff (!arst_n)
      ton_max_fault[i] |-> $past(t_max) != 16'h0000)
      else $error("fault raised with timeout disabled");
    AST_OFF_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(converter_enable_out[i]) && !$past(restart_hold) |->
        $past(cnt) >= $past(t_off))
      else $error("disable before off-delay");
    AST_CLAMP: assert property (@(posedge clk) disable iff (!arst_n)
      (t_on <= MAX_COUNT) && (t_off <= MAX_COUNT) && (t_max <= MAX_COUNT))
      else $error("timer not clamped");
  end

  AST_READBACK_RAW: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.wr && reg_req.cmd == CMD_RESTART) ##1
      (!reg_req.wr && reg_req.cmd == CMD_RESTART) |=>
      reg_rd_data == $past(reg_req.wdata, 2))
    else $error("readback differs from written word");
  AST_RESTART_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(restart_hold) |-> $past(ctrl_pin) && !$past(ctrl_q) &&
      ($past(rs_val) != 16'h0000) ##1 (converter_enable_out == '0))
    else $error("restart hold without valid trigger");
endmodule // sst_top
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the supply sequencing timers.
// Assumes the far side model supplies the shared clock and converters.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sst_pkg::*;
  typedef struct {logic wr; logic [7:0] cmd; logic [1:0] page; logic [15:0] d;} sst_row_type;
  logic clk, arst_n, ctrl_pin, share_in, share_out, share_oe, restart_hold;
  sst_req_type reg_req;
  logic [15:0] rd_data, got;
  logic [3:0] op_on, dac_zero, uv_ok, en, servo, unmask, fault, seen_fault;
  int failures, compares, n;
  sst_row_type rows [10];

  sst_top #(.N_CH(4)) i_dut (.clk(clk), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rd_data(rd_data), .ctrl_pin(ctrl_pin), .op_on(op_on), .dac_mode_zero(dac_zero),
    .uv_ok(uv_ok), .share_clk_in(share_in), .share_clk_out(share_out),
    .share_clk_oe(share_oe), .converter_enable_out(en), .servo_engage(servo),
    .uv_unmask(unmask), .ton_max_fault(fault), .restart_hold(restart_hold));
  sst_far_side i_far (.clk(clk), .arst_n(arst_n), .share_clk_out(share_out),
    .share_clk_oe(share_oe), .converter_enable_out(en), .good_mask(4'hE),
    .share_clk_in(share_in), .uv_ok(uv_ok));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] exp, input logic [15:0] act);
    compares++;
    if (act !== exp)
    begin
      failures++;
      $display("Error at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask
  task automatic chk_rng(input int lo, input int hi, input int act);
    compares++;
    if (act < lo || act > hi)
    begin
      failures++;
      $display("Error at %0t: expected %h..%h, got %h", $time, lo, hi, act);
    end
  endtask
  task automatic wr_reg(input logic [7:0] c, input logic [1:0] p, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{1'b1, p, c, d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] c, input logic [1:0] p, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{1'b0, p, c, 16'h0000};
    repeat (2) @(posedge clk);
    #1 d = rd_data;
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return en[0];
      1: return servo[0];
      2: return fault[0];
      3: return !en[0];
      4: return restart_hold;
      default: return !restart_hold;
    endcase
  endfunction
  // Counts cycles until the chosen condition is true (k 3 and 5 wait for a low level); stops at lim.
  task automatic wait_sig(input int k, input int lim);
    n = 0;
    while (sel(k) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic ctrl_pulse(input int len);
    @(posedge clk);
    ctrl_pin <= 1'b0;
    repeat (len) @(posedge clk);
    ctrl_pin <= 1'b1;
  endtask
  task automatic finish_test();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and fault monitor
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #(60000 * 100);
    failures++;
    finish_test();
  end
  always @(posedge clk)
    seen_fault <= arst_n ? (seen_fault | fault) : 4'h0;

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rows = '{'{0, CMD_ON_DELAY, 0, RST_ON_DELAY}, '{0, CMD_RISE, 1, RST_RISE},
      '{0, CMD_MAX_ON, 2, RST_MAX_ON}, '{0, CMD_OFF_DELAY, 3, RST_OFF_DELAY},
      '{0, CMD_RESTART, 0, RST_RESTART}, '{0, 8'h63, 0, 16'h0000},
      '{1, CMD_MAX_ON, 1, 16'h7FFF}, '{1, CMD_OFF_DELAY, 2, 16'h8001},
      '{1, CMD_RESTART, 1, 16'h1234}, '{0, CMD_RESTART, 3, 16'h1234}};
    arst_n = 1'b0;
    ctrl_pin = 1'b1;
    op_on = 4'h0;
    dac_zero = 4'hD;
    reg_req = '0;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr_reg(rows[i].cmd, rows[i].page, rows[i].d);
      rd_reg(rows[i].cmd, rows[i].page, got);
      chk(rows[i].d, got);
    end
    $display("Test registers done");
    // Steps: 0xE001 is 6 ticks, 0xE002 is 13 ticks, 0xE008 is 3 restart steps.
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(CMD_ON_DELAY, 2'(c), 16'hE001);
      wr_reg(CMD_RISE, 2'(c), 16'hE001);
      wr_reg(CMD_MAX_ON, 2'(c), (c == 2) ? 16'h0000 : 16'hE002);
      wr_reg(CMD_OFF_DELAY, 2'(c), 16'hE001);
    end
    wr_reg(CMD_RESTART, 2'd0, 16'hE008);
    @(posedge clk);
    op_on <= 4'hF;
    wait_sig(0, 2000);
    chk_rng(500, 800, n);
    wait_sig(1, 2000);
    chk_rng(500, 800, n);
    wait_sig(2, 2000);
    chk_rng(500, 900, n);
    repeat (20) @(posedge clk);
    chk(16'h0001, {12'h000, seen_fault});
    chk(16'h000E, {12'h000, unmask});
    chk(16'h000D, {12'h000, servo});
    @(posedge clk);
    op_on <= 4'h0;
    wait_sig(3, 2000);
    chk_rng(500, 800, n);
    $display("Test on and off sequence done");
    @(posedge clk);
    op_on <= 4'hF;
    wait_sig(0, 2000);
    ctrl_pulse(300);
    wait_sig(4, 10);
    chk_rng(0, 3, n);
    repeat (2) @(posedge clk);
    #1 chk(16'h0000, {12'h000, en});
    wait_sig(5, 10000);
    chk_rng(4000, 8100, n);
    wait_sig(0, 2000);
    chk_rng(500, 800, n);
    ctrl_pulse(8500);
    wait_sig(4, 50);
    chk_rng(50, 50, n);
    wr_reg(CMD_RESTART, 2'd0, 16'h0000);
    ctrl_pulse(300);
    wait_sig(4, 50);
    chk_rng(50, 50, n);
    $display("Test restart done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(16'h0000, {en, servo, unmask, fault});
    chk(16'h0000, {14'h0000, share_out, share_oe});
    arst_n <= 1'b1;
    rd_reg(CMD_RESTART, 2'd2, got);
    chk(RST_RESTART, got);
    $display("Test reset done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
